//--- inc/selr_pkg.sv
// Purpose: Shared constants and types for the lock-status and serial-number
//          read block of a serial EEPROM slave.
// Assumes: One system clock of 40 MHz samples the serial link pins.
// Notes:   Nothing here is synthesised on its own.
//
// Functional notes
// - Opcode 83h with region bits 10 selects a lock-status read.
// - Bit 1 of the returned status byte is the sector locked flag.
// - The status byte repeats every eight clocks while select stays low.
// - Select high ends any special read at once.
// - Frame is select low, eight opcode bits, then sixteen address bits.
// - Address bit 9 set selects the serial-number read; upper bits ignored.
// - Address bits 3 to 0 give the starting serial-number byte.
// - The 128-bit serial number is fixed and never writable.
// - Output bits change on falling serial-clock edges after the address.
// - After byte fifteen the serial-number index wraps to byte zero.
// - Opcode and address bits are captured on rising serial-clock edges.
// - Region bits 00 return security-sector data bytes instead.
// - Lock flag is set only by an enabled lock command with bit 1 set.
// - Security-sector reads are refused while a write cycle runs.
package selr_pkg;
    localparam logic [7:0] SELR_OP_SPECIAL_READ = 8'h83;
    localparam int         SELR_OP_BITS         = 8;
    localparam int         SELR_ADDR_BITS       = 16;
    localparam int         SELR_HDR_BITS        = SELR_OP_BITS + SELR_ADDR_BITS;
    localparam int         SELR_LOCK_BIT        = 1;
    localparam int         SELR_REGION_HI       = 10;
    localparam int         SELR_REGION_LO       = 9;
    localparam int         SELR_SERNUM_SEL_BIT  = 9;
    localparam logic [1:0] SELR_REGION_SECTOR   = 2'h0;
    localparam logic [1:0] SELR_REGION_LOCK     = 2'h2;
    localparam int         SELR_SERNUM_BYTES    = 16;
    localparam int         SELR_SECTOR_BYTES    = 32;
    // Arbitrary value; each real part carries its own fixed number.
    localparam logic [127:0] SELR_SERNUM_DEFAULT =
        128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;

    typedef enum logic [2:0] {
        SELR_IDLE   = 3'h0,
        SELR_HEADER = 3'h1,
        SELR_DATA   = 3'h3,
        SELR_IGNORE = 3'h2
    } selr_state_t;

    typedef enum logic [1:0] {
        SELR_SRC_LOCK   = 2'h0,
        SELR_SRC_SERNUM = 2'h1,
        SELR_SRC_SECTOR = 2'h2
    } selr_src_t;

    // Synchronised view of the three link inputs.
    typedef struct packed {
        logic sel_n;
        logic sclk;
        logic sdi;
    } selr_link_t;
endpackage

//--- src/selr_special_read.sv
// Purpose: Device-side shifter for lock-status, serial-number and sector
//          reads that share one opcode on the serial link.
// Assumes: Link pins are asynchronous and sampled by clock_i at 40 MHz;
//          serial clock is slow enough to be seen high and low (mode 0/3).
// Notes:   Sector data and write-in-progress come from the array logic.
`timescale 1ns/1ps
module selr_special_read #(
    parameter logic [127:0] SERNUM_VALUE = selr_pkg::SELR_SERNUM_DEFAULT
) (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        sel_n_i,
    input  wire logic        sclk_i,
    input  wire logic        serial_in_pin_i,
    input  wire logic        sector_locked_flag_i,
    input  wire logic        write_busy_i,
    input  wire logic [7:0]  sector_data_i,
    output logic      [4:0]  sector_index_o,
    output logic             sdo_o,
    output logic             sdo_oe_o
);
    // SERNUM_VALUE is arbitrary; each part carries its own fixed number.
    // It has no write path, so no instruction can alter it.

    selr_pkg::selr_link_t meta_r, sync_r, prev_r;
    selr_pkg::selr_state_t state_r, state_nxt;
    selr_pkg::selr_src_t   src_r, src_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [23:0] hdr_r, hdr_nxt;
    logic [2:0]  bit_r, bit_nxt;
    logic [4:0]  idx_r, idx_nxt;
    logic [7:0]  byte_r, byte_nxt;
    logic        sdo_r, sdo_nxt;
    logic        oe_r, oe_nxt;
    logic        rise, fall, sel_act;
    logic        sernum_sel;
    logic [23:0] hdr_full;
    logic [15:0] addr;
    logic [1:0]  region;
    logic [7:0]  start_byte;

    // Two stages before any logic looks at a pin.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            meta_r <= '{sel_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
            sync_r <= '{sel_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
            prev_r <= '{sel_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
        end else begin
            meta_r <= '{sel_n: sel_n_i, sclk: sclk_i, sdi: serial_in_pin_i};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign sel_act  = !sync_r.sel_n;
    assign rise     = sel_act && sync_r.sclk && !prev_r.sclk;
    assign fall     = sel_act && !sync_r.sclk && prev_r.sclk;
    assign hdr_full = {hdr_r[22:0], sync_r.sdi};
    assign addr     = hdr_full[selr_pkg::SELR_ADDR_BITS-1:0];
    assign region   = addr[selr_pkg::SELR_REGION_HI:selr_pkg::SELR_REGION_LO];
    assign sernum_sel = addr[selr_pkg::SELR_SERNUM_SEL_BIT];

    function automatic logic [7:0] sernum_byte(input logic [3:0] i);
        sernum_byte = SERNUM_VALUE[127 - 8 * i -: 8];
    endfunction

    always_comb begin
        start_byte = 8'h00;
        case (src_r)
            selr_pkg::SELR_SRC_LOCK: begin
                start_byte = 8'h00;
                // Only the lock path sets this flag, and only for an enabled
                // lock command whose data bit 1 is one.
                start_byte[selr_pkg::SELR_LOCK_BIT] = sector_locked_flag_i;
            end
            selr_pkg::SELR_SRC_SERNUM: start_byte = sernum_byte(idx_r[3:0]);
            selr_pkg::SELR_SRC_SECTOR: start_byte = sector_data_i;
            default:                   start_byte = 8'h00;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        src_nxt   = src_r;
        cnt_nxt   = cnt_r;
        hdr_nxt   = hdr_r;
        bit_nxt   = bit_r;
        idx_nxt   = idx_r;
        byte_nxt  = byte_r;
        sdo_nxt   = sdo_r;
        oe_nxt    = oe_r;
        if (!sel_act) begin
            // Select high aborts everything and releases the line.
            state_nxt = selr_pkg::SELR_IDLE;
            oe_nxt    = 1'b0;
            cnt_nxt   = 5'h00;
        end else begin
            case (state_r)
                selr_pkg::SELR_IDLE: begin
                    state_nxt = selr_pkg::SELR_HEADER;
                    cnt_nxt   = 5'h00;
                end
                selr_pkg::SELR_HEADER: begin
                    if (rise) begin
                        hdr_nxt = hdr_full;
                        cnt_nxt = cnt_r + 5'h01;
                        if (cnt_r == 5'(selr_pkg::SELR_HDR_BITS - 1)) begin
                            state_nxt = selr_pkg::SELR_DATA;
                            bit_nxt   = 3'h7;
                            if (hdr_full[23:16] != selr_pkg::SELR_OP_SPECIAL_READ)
                                state_nxt = selr_pkg::SELR_IGNORE;
                            else if (region == selr_pkg::SELR_REGION_LOCK)
                                src_nxt = selr_pkg::SELR_SRC_LOCK;
                            else if (sernum_sel) begin
                                src_nxt = selr_pkg::SELR_SRC_SERNUM;
                                idx_nxt = {1'b0, addr[3:0]};
                            end else if (region == selr_pkg::SELR_REGION_SECTOR
                                         && !write_busy_i) begin
                                src_nxt = selr_pkg::SELR_SRC_SECTOR;
                                idx_nxt = addr[4:0];
                            end else
                                state_nxt = selr_pkg::SELR_IGNORE;
                        end
                    end
                end
                selr_pkg::SELR_DATA: begin
                    if (fall) begin
                        oe_nxt = 1'b1;
                        if (bit_r == 3'h7) begin
                            sdo_nxt  = start_byte[7];
                            byte_nxt = {start_byte[6:0], 1'b0};
                        end else begin
                            sdo_nxt  = byte_r[7];
                            byte_nxt = {byte_r[6:0], 1'b0};
                        end
                        bit_nxt = bit_r - 3'h1;
                        if (bit_r == 3'h0) begin
                            // Lock status never advances.
                            if (src_r == selr_pkg::SELR_SRC_SERNUM)
                                idx_nxt = {1'b0, idx_r[3:0] + 4'h1};
                            else if (src_r == selr_pkg::SELR_SRC_SECTOR)
                                idx_nxt = idx_r + 5'h01;
                        end
                    end
                end
                selr_pkg::SELR_IGNORE: oe_nxt = 1'b0;
                default: state_nxt = selr_pkg::SELR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_r <= selr_pkg::SELR_IDLE;
            src_r   <= selr_pkg::SELR_SRC_LOCK;
            cnt_r   <= 5'h00;
            hdr_r   <= 24'h000000;
            bit_r   <= 3'h7;
            idx_r   <= 5'h00;
            byte_r  <= 8'h00;
            sdo_r   <= 1'b0;
            oe_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            src_r   <= src_nxt;
            cnt_r   <= cnt_nxt;
            hdr_r   <= hdr_nxt;
            bit_r   <= bit_nxt;
            idx_r   <= idx_nxt;
            byte_r  <= byte_nxt;
            sdo_r   <= sdo_nxt;
            oe_r    <= oe_nxt;
        end
    end

    assign sdo_o          = sdo_r;
    assign sdo_oe_o       = oe_r;
    assign sector_index_o = idx_r;
endmodule

//--- verif/selr_special_read_chk.sv
// Purpose: Port-level timing checks for the special read block.
// Assumes: Link pins reach the block through its own synchronisers.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
module selr_special_read_chk (
    input wire logic       clock_i,
    input wire logic       sys_rst_i,
    input wire logic       sel_n_i,
    input wire logic       sclk_i,
    input wire logic [4:0] sector_index_o,
    input wire logic       sdo_o,
    input wire logic       sdo_oe_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic       sclk_q_r;
    logic [4:0] rise_cnt_r;
    // Raw pin rises are counted; the block sees them later, never earlier.
    always_ff @(posedge clock_i) begin
        sclk_q_r <= sclk_i;
        if (sys_rst_i || sel_n_i) rise_cnt_r <= 5'h00;
        else if (sclk_i && !sclk_q_r && rise_cnt_r != 5'h1F)
            rise_cnt_r <= rise_cnt_r + 5'h01;
    end
    property p_rst;
        disable iff (1'b0) sys_rst_i |=> !sdo_oe_o && !sdo_o &&
            sector_index_o == 5'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
    property p_idle; sel_n_i [*5] |-> !sdo_oe_o; endproperty
    a_idle: assert property (p_idle) else $error("driving while idle");
    property p_hold; (!sel_n_i) [*5] ##0 sdo_oe_o |=> sdo_oe_o; endproperty
    a_hold: assert property (p_hold) else $error("drive dropped early");
    property p_off; $fell(sdo_oe_o) |-> sel_n_i; endproperty
    a_off: assert property (p_off) else $error("drive dropped in frame");
    property p_hdr; $rose(sdo_oe_o) |-> rise_cnt_r >= 5'h18; endproperty
    a_hdr: assert property (p_hdr) else $error("data before header");
    property p_rise; $rose(sdo_oe_o) |-> !sclk_i && $past(sclk_i, 5); endproperty
    a_rise: assert property (p_rise) else $error("drive not on fall");
    property p_stable; sclk_i [*3] |-> $stable(sdo_o); endproperty
    a_stable: assert property (p_stable) else $error("data moved on high");
    property p_gap; $changed(sdo_o) && sdo_oe_o |=> $stable(sdo_o) [*4];
    endproperty
    a_gap: assert property (p_gap) else $error("data moved twice");
    c_start: cover property ($rose(sdo_oe_o));
    c_end: cover property ($fell(sdo_oe_o));
    c_hdr: cover property (rise_cnt_r == 5'h18);
endmodule
bind selr_special_read selr_special_read_chk u_chk (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .sel_n_i(sel_n_i), .sclk_i(sclk_i),
    .sector_index_o(sector_index_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o));

//--- verif/selr_host.sv
// Purpose: Serial host model, mode 0, 200 ns link clock.
// Assumes: Driven from falling edges of the system clock.
// Notes:   Input line shows the inverse of its last value when unused.
`timescale 1ns/1ps
module selr_host (
    input  wire logic clock_i,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i,
    output logic      sel_n_o,
    output logic      sclk_o,
    output logic      sdi_o
);
    logic held_r = 1'b0;
    logic miso;
    // A released line drifts to the inverse of its last driven level, so a
    // late enable shows up as wrong data instead of a lucky match.
    always @(posedge clock_i) begin
        if (sdo_oe_i) begin
            held_r <= sdo_i;
        end
    end
    assign miso = sdo_oe_i ? sdo_i : ~held_r;
    initial begin
        sel_n_o = 1'b1;
        sclk_o  = 1'b0;
        sdi_o   = 1'b0;
    end
    task automatic frame(input logic [23:0] hdr, input int nbits,
                         output logic [23:0] rx, output logic oe_seen);
        rx      = 24'h000000;
        oe_seen = 1'b0;
        sel_n_o = 1'b0;
        repeat (4) @(negedge clock_i);
        for (int i = 0; i < 24 + nbits; i++) begin
            sdi_o  = (i < 24) ? hdr[23 - i] : ~sdi_o;
            sclk_o = 1'b0;
            repeat (5) @(negedge clock_i);
            if (i >= 24) begin
                rx      = {rx[22:0], miso};
                oe_seen = oe_seen | sdo_oe_i;
            end
            sclk_o = 1'b1;
            repeat (3) @(negedge clock_i);
        end
        sclk_o = 1'b0;
        repeat (5) @(negedge clock_i);
        sel_n_o = 1'b1;
        sdi_o   = ~sdi_o;
        repeat (6) @(negedge clock_i);
    endtask
endmodule

//--- verif/selr_special_read_tb.sv
// Purpose: Self-checking bench for the special read block.
// Assumes: Sector array stand-in returns a pattern built from the index.
// Notes:   Serial number expected from the default parameter value.
`timescale 1ns/1ps
module selr_special_read_tb;
    typedef struct {
        logic [23:0] hdr;
        logic        flag;
        logic        busy;
        int          nb;
        logic [23:0] exp;
        logic [23:0] msk;
        logic        oe;
    } selr_row_t;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        flag_r = 1'b0;
    logic        busy_r = 1'b0;
    logic        sel_n, sclk, sdi, sdo, sdo_oe, oe_seen;
    logic [4:0]  idx;
    logic [23:0] rx;
    int          bad_count = 0;
    int          comparisons = 0;
    selr_row_t   rows [8];
    always #12.5 clock_i = ~clock_i;
    selr_host u_host (.clock_i(clock_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
        .sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi));
    selr_special_read uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .sel_n_i(sel_n), .sclk_i(sclk), .serial_in_pin_i(sdi),
        .sector_locked_flag_i(flag_r), .write_busy_i(busy_r),
        .sector_data_i({3'h5, idx}), .sector_index_o(idx), .sdo_o(sdo),
        .sdo_oe_o(sdo_oe));
    function automatic logic [7:0] uidb(int k);
        return selr_pkg::SELR_SERNUM_DEFAULT[127 - 8 * (k % 16) -: 8];
    endfunction
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #1000000;
        bad_count++;
        final_report();
    end
    initial begin
        rows[0] = '{24'h830400, 0, 0, 16, 24'h0, 24'h0202, 1};
        rows[1] = '{24'h83FC00, 1, 0, 16, 24'h0202, 24'h0202, 1};
        rows[2] = '{24'h830200, 0, 0, 24, {uidb(0), uidb(1), uidb(2)},
                    24'hFFFFFF, 1};
        rows[3] = '{24'h83F20F, 0, 0, 16, {8'h00, uidb(15), uidb(0)},
                    24'hFFFF, 1};
        rows[4] = '{24'h830603, 0, 0, 8, {16'h0, uidb(3)}, 24'hFF, 1};
        rows[5] = '{24'h83001F, 0, 0, 16, 24'hBFA0, 24'hFFFF, 1};
        rows[6] = '{24'h030200, 0, 0, 8, 24'h0, 24'h0, 0};
        rows[7] = '{24'h830000, 0, 1, 8, 24'h0, 24'h0, 0};
        repeat (10) @(negedge clock_i);
        sys_rst_i = 1'b0;
        repeat (4) @(negedge clock_i);
        foreach (rows[i]) begin
            flag_r = rows[i].flag;
            busy_r = rows[i].busy;
            u_host.frame(rows[i].hdr, rows[i].nb, rx, oe_seen);
            check(rx & rows[i].msk, rows[i].exp);
            check(oe_seen, rows[i].oe);
            if (i < 2) check(rx[15:8], rx[7:0]);
            $display("test %0d done", i);
        end
        sys_rst_i = 1'b1;
        repeat (3) @(negedge clock_i);
        check({sdo_oe, sdo, idx}, 24'h0);
        sys_rst_i = 1'b0;
        repeat (4) @(negedge clock_i);
        u_host.frame(24'h83FE0E, 8, rx, oe_seen);
        check(rx[7:0], uidb(14));
        $display("test reset done");
        final_report();
    end
endmodule
